// ===== design/mmd_memory_map_defs.vh
/*
  Constants for the memory map decoder: file addresses, bus word
  indices, field positions, reset values and variant codes.
  Assumes it is included by its bare name from the design file.
*/
`ifndef MMD_MEMORY_MAP_DEFS_VH
`define MMD_MEMORY_MAP_DEFS_VH

// ==========================================================
// Register file addresses
`define MMD_A_INDIRECT   5'h00
`define MMD_A_TIMER      5'h01
`define MMD_A_PCL        5'h02
`define MMD_A_STATUS     5'h03
`define MMD_A_FPTR       5'h04
`define MMD_A_PIN_A      5'h05
`define MMD_A_PIN_B      5'h06
`define MMD_A_PIN_C      5'h07
`define MMD_A_GP_FIRST   5'h08
`define MMD_A_BANK_FIRST 5'h10

// ==========================================================
// Bus word indices: top of the register file and words beyond it
`define MMD_I_FILE_TOP   8'h1f
`define MMD_I_DIR_A      8'h20
`define MMD_I_DIR_B      8'h21
`define MMD_I_DIR_C      8'h22
`define MMD_I_OPTION     8'h23
`define MMD_I_PC         8'h24

// ==========================================================
// Status fields
`define MMD_ST_PAGE_HI   6
`define MMD_ST_PAGE_LO   5
`define MMD_ST_TO        4
`define MMD_ST_PD        3
`define MMD_ST_WR_MASK   8'he7

// ==========================================================
// Reset values and fixed pointer read bits
`define MMD_RST_STATUS   8'h18
`define MMD_RST_FPTR     8'h00
`define MMD_RST_DIR      8'hff
`define MMD_RST_OPTION   6'h3f
`define MMD_FPTR_FIX_UNB 8'he0
`define MMD_FPTR_FIX_BNK 8'h80

// ==========================================================
// Variant codes
`define MMD_V_512        3'h0
`define MMD_V_512_PC     3'h1
`define MMD_V_1K         3'h2
`define MMD_V_2K_PC      3'h3
`define MMD_V_2K         3'h4

`endif

// ===== design/mmd_memory_map.v
/*
  Memory map decoder of a small 8-bit controller: program counter,
  paging, register file with special and general registers, direct
  and pointer addressing, bank selection, and an Avalon-MM slave.
  Assumes one clock, a core on the same clock, and asynchronous pins
  that are synchronised here before use.
*/
// Summary of operation
// - Program counter is 9, 10 or 11 bits
// - Addresses beyond implemented space wrap around
// - Reset starts fetch at last program word
// - Increment past reset vector wraps to zero
// - Status page bits select upper program page
// - Pointer bits select data bank on large parts
// - Operands addressed directly or through pointer
// - Small parts: 7 special, 25 general registers
// - Small third-port part: 8 special, 24 general
// - Large third-port part adds 48 banked registers
// - Large part without port adds 48 banked
// - Address zero redirects through the file pointer
// - Core registers mapped upward from address one
// - Address seven is third port or general
// - General registers from 08h through 1Fh
// - Direction and prescaler kept outside the map
// - Only low program counter byte is in the file; bus reads the whole counter
`timescale 1ns/100ps
`include "mmd_memory_map_defs.vh"

module mmd_memory_map #(
  parameter [2:0] VARIANT = `MMD_V_2K
) (
  input  wire        sys_clk,
  input  wire        arst_n,
  // Core fetch side
  input  wire        fetch_advance,
  input  wire        jump_valid,
  input  wire [8:0]  jump_target,
  output reg  [10:0] prog_addr,
  // Core operand side
  input  wire        op_valid,
  input  wire        op_write,
  input  wire [4:0]  op_addr,
  input  wire [7:0]  op_wdata,
  output reg  [7:0]  op_rdata,
  output reg         op_ready,
  input  wire        flags_we,
  input  wire [2:0]  flags_in,
  input  wire        dir_we,
  input  wire [1:0]  dir_sel,
  input  wire [7:0]  dir_wdata,
  input  wire        option_we,
  input  wire [5:0]  option_wdata,
  output reg  [5:0]  option_value,
  // Pins
  input  wire [3:0]  pin_a_in,
  output reg  [3:0]  pin_a_out,
  output reg  [3:0]  pin_a_oe,
  input  wire [7:0]  pin_b_in,
  output reg  [7:0]  pin_b_out,
  output reg  [7:0]  pin_b_oe,
  input  wire [7:0]  pin_c_in,
  output reg  [7:0]  pin_c_out,
  output reg  [7:0]  pin_c_oe,
  // Avalon-MM slave
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest
);

  // ==========================================================
  // Variant shape
  // Counter width per variant; unused high bits are masked off
  localparam PC_W = (VARIANT == `MMD_V_2K || VARIANT == `MMD_V_2K_PC) ?
                    11 : ((VARIANT == `MMD_V_1K) ? 10 : 9);
  localparam [10:0] PC_MASK = (PC_W == 11) ? 11'h7ff :
                              ((PC_W == 10) ? 11'h3ff : 11'h1ff);
  localparam HAS_PORT_C = (VARIANT == `MMD_V_512_PC) ||
                          (VARIANT == `MMD_V_2K_PC);
  localparam BANKED = (VARIANT == `MMD_V_2K) ||
                      (VARIANT == `MMD_V_2K_PC);
  localparam [7:0] FPTR_FIX = BANKED ? `MMD_FPTR_FIX_BNK :
                                       `MMD_FPTR_FIX_UNB;

  // ==========================================================
  // State
  reg  [10:0] pc_reg;
  reg  [7:0]  timer_count_reg;
  reg  [7:0]  status_flags_reg;
  reg  [7:0]  file_pointer_reg;
  reg  [7:0]  latch_a_reg;
  reg  [7:0]  latch_b_reg;
  reg  [7:0]  latch_c_reg;
  reg  [7:0]  dir_a_reg;
  reg  [7:0]  dir_b_reg;
  reg  [7:0]  dir_c_reg;
  reg  [5:0]  option_reg;
  reg  [19:0] pin_meta_reg;
  reg  [19:0] pin_sync_reg;
  reg  [7:0]  gp_mem [0:127];

  reg  [10:0] pc_next;
  reg         acc_go;
  reg         acc_core;
  reg         acc_wr;
  reg  [7:0]  acc_idx;
  reg  [7:0]  acc_wdata;
  reg  [4:0]  eff_addr;
  reg  [6:0]  phys;
  reg  [7:0]  file_rdata;
  reg  [7:0]  acc_rdata;
  reg         file_space;
  reg  [7:0]  status_next;

  wire [3:0]  sync_a = pin_sync_reg[3:0];
  wire [7:0]  sync_b = pin_sync_reg[11:4];
  wire [7:0]  sync_c = pin_sync_reg[19:12];

  // ==========================================================
  // Physical index of a general register
  // Common registers below 10h ignore the bank so that every bank
  // sees the same 08h-0Fh block; upper half is banked on large parts.
  function [6:0] gp_index;
    input [4:0] addr;
    input [7:0] fptr;
    begin
      if (BANKED && addr >= `MMD_A_BANK_FIRST)
        gp_index = {fptr[6:5], addr};
      else
        gp_index = {2'b00, addr};
    end
  endfunction

  // Address seven holds storage unless the third port exists
  function is_gp;
    input [4:0] addr;
    begin
      if (addr == `MMD_A_PIN_C)
        is_gp = !HAS_PORT_C;
      else
        is_gp = (addr >= `MMD_A_GP_FIRST);
    end
  endfunction

  // ==========================================================
  // Access arbitration
  // The core wins every cycle; the bus is served only when the core
  // is idle, so a busy core can hold waitrequest high indefinitely.
  always @* begin
    acc_core  = op_valid;
    acc_go    = 1'b0;
    acc_wr    = 1'b0;
    acc_idx   = 8'h00;
    acc_wdata = 8'h00;
    if (op_valid) begin
      acc_go    = 1'b1;
      acc_wr    = op_write;
      acc_idx   = {3'b000, op_addr};
      acc_wdata = op_wdata;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      acc_go    = 1'b1;
      acc_wr    = avs_write && avs_byteenable[0];
      acc_idx   = avs_address[9:2];
      acc_wdata = avs_writedata[7:0];
    end
  end

  // ==========================================================
  // Operand decode
  // Zero in the address field means use the pointer as the address
  always @* begin
    file_space = (acc_idx <= `MMD_I_FILE_TOP);
    if (acc_idx[4:0] == `MMD_A_INDIRECT)
      eff_addr = file_pointer_reg[4:0];
    else
      eff_addr = acc_idx[4:0];
    phys = gp_index(eff_addr, file_pointer_reg);
  end

  // Read data of the register file, general registers first
  always @* begin
    if (is_gp(eff_addr))
      file_rdata = gp_mem[phys];
    else begin
      case (eff_addr)
        `MMD_A_INDIRECT: file_rdata = 8'h00; // Pointer to itself
        `MMD_A_TIMER:    file_rdata = timer_count_reg;
        `MMD_A_PCL:      file_rdata = pc_reg[7:0];
        `MMD_A_STATUS:   file_rdata = status_flags_reg;
        `MMD_A_FPTR:     file_rdata = file_pointer_reg | FPTR_FIX;
        `MMD_A_PIN_A:    file_rdata = {4'h0, sync_a};
        `MMD_A_PIN_B:    file_rdata = sync_b;
        `MMD_A_PIN_C:    file_rdata = sync_c;
        default:         file_rdata = 8'h00;
      endcase
    end
  end

  // Bus-only words: direction and prescaler; the whole counter is read at the bus answer
  always @* begin
    if (file_space)
      acc_rdata = file_rdata;
    else begin
      case (acc_idx)
        `MMD_I_DIR_A:  acc_rdata = dir_a_reg;
        `MMD_I_DIR_B:  acc_rdata = dir_b_reg;
        `MMD_I_DIR_C:  acc_rdata = dir_c_reg;
        `MMD_I_OPTION: acc_rdata = {2'b00, option_reg};
        default:       acc_rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Program counter next value
  // A low-byte write clears bit 8 and takes the page from status;
  // upper bits are never written directly.
  always @* begin
    pc_next = pc_reg;
    if (acc_go && acc_wr && file_space && eff_addr == `MMD_A_PCL)
      pc_next = {status_flags_reg[`MMD_ST_PAGE_HI:`MMD_ST_PAGE_LO],
                 1'b0, acc_wdata} & PC_MASK;
    else if (jump_valid)
      pc_next = {status_flags_reg[`MMD_ST_PAGE_HI:`MMD_ST_PAGE_LO],
                 jump_target} & PC_MASK;
    else if (fetch_advance)
      pc_next = (pc_reg + 11'h001) & PC_MASK;
  end

  // Status next value: flag hardware wins over a file write
  always @* begin
    status_next = status_flags_reg;
    if (acc_go && acc_wr && file_space && eff_addr == `MMD_A_STATUS)
      status_next = (acc_wdata & `MMD_ST_WR_MASK) |
                    (status_flags_reg & ~`MMD_ST_WR_MASK);
    if (flags_we)
      status_next = {status_next[7:3], flags_in};
  end

  // ==========================================================
  // Pin synchronisers
  // Two stages on every pin; only the second stage is read
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_reg <= 20'h00000;
      pin_sync_reg <= 20'h00000;
    end else begin
      pin_meta_reg <= {pin_c_in, pin_b_in, pin_a_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ==========================================================
  // Register state
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg           <= PC_MASK;
      timer_count_reg  <= 8'h00;
      status_flags_reg <= `MMD_RST_STATUS;
      file_pointer_reg <= `MMD_RST_FPTR;
      latch_a_reg      <= 8'h00;
      latch_b_reg      <= 8'h00;
      latch_c_reg      <= 8'h00;
      dir_a_reg        <= `MMD_RST_DIR;
      dir_b_reg        <= `MMD_RST_DIR;
      dir_c_reg        <= `MMD_RST_DIR;
      option_reg       <= `MMD_RST_OPTION;
    end else begin
      pc_reg           <= pc_next;
      status_flags_reg <= status_next;
      if (acc_go && acc_wr && file_space) begin
        case (eff_addr)
          `MMD_A_TIMER: timer_count_reg  <= acc_wdata;
          `MMD_A_FPTR:  file_pointer_reg <= acc_wdata;
          `MMD_A_PIN_A: latch_a_reg      <= {4'h0, acc_wdata[3:0]};
          `MMD_A_PIN_B: latch_b_reg      <= acc_wdata;
          `MMD_A_PIN_C: begin
            if (HAS_PORT_C)
              latch_c_reg <= acc_wdata;
          end
          default: ;
        endcase
      end
      // Direction and prescaler: core strobes, or bus-only words
      if (dir_we) begin
        case (dir_sel)
          2'h0:    dir_a_reg <= dir_wdata;
          2'h1:    dir_b_reg <= dir_wdata;
          2'h2:    dir_c_reg <= dir_wdata;
          default: ;
        endcase
      end else if (acc_go && acc_wr && !acc_core) begin
        case (acc_idx)
          `MMD_I_DIR_A: dir_a_reg <= acc_wdata;
          `MMD_I_DIR_B: dir_b_reg <= acc_wdata;
          `MMD_I_DIR_C: dir_c_reg <= acc_wdata;
          default: ;
        endcase
      end
      if (option_we)
        option_reg <= option_wdata;
      else if (acc_go && acc_wr && !acc_core &&
               acc_idx == `MMD_I_OPTION)
        option_reg <= acc_wdata[5:0];
    end
  end

  // General storage has no reset, as the real file is unknown at power
  always @(posedge sys_clk) begin
    if (acc_go && acc_wr && file_space && is_gp(eff_addr))
      gp_mem[phys] <= acc_wdata;
  end

  // ==========================================================
  // Answers to core and bus
  // Waitrequest is low for exactly the one cycle after service, so
  // the master samples it with the data and then drops the request.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_rdata        <= 8'h00;
      op_ready        <= 1'b0;
      avs_readdata    <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      op_ready        <= acc_go && acc_core;
      avs_waitrequest <= !(acc_go && !acc_core);
      if (acc_go && acc_core)
        op_rdata <= acc_rdata;
      if (acc_go && !acc_core) begin
        if (acc_idx == `MMD_I_PC)
          avs_readdata <= {21'h000000, pc_reg};
        else
          avs_readdata <= {24'h000000, acc_rdata};
      end
    end
  end

  // ==========================================================
  // Registered outputs
  // Output enable is the inverse of the direction bit (1 = input)
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_addr    <= PC_MASK;
      option_value <= `MMD_RST_OPTION;
      pin_a_out    <= 4'h0;
      pin_a_oe     <= 4'h0;
      pin_b_out    <= 8'h00;
      pin_b_oe     <= 8'h00;
      pin_c_out    <= 8'h00;
      pin_c_oe     <= 8'h00;
    end else begin
      prog_addr    <= pc_next;
      option_value <= option_reg;
      pin_a_out    <= latch_a_reg[3:0];
      pin_a_oe     <= ~dir_a_reg[3:0];
      pin_b_out    <= latch_b_reg;
      pin_b_oe     <= ~dir_b_reg;
      pin_c_out    <= HAS_PORT_C ? latch_c_reg : 8'h00;
      pin_c_oe     <= HAS_PORT_C ? ~dir_c_reg : 8'h00;
    end
  end

endmodule // mmd_memory_map

// ===== sim/mmd_map_monitor.sv
/*
  Checker for the memory map decoder: counter width, reset vector,
  wrap, jumps and handshakes. Assumes it is bound to the top module.
*/
`timescale 1ns/100ps
// ========================================
// Checker
module mmd_map_monitor #(
  parameter [2:0] VARIANT = 3'h4
) (
  input wire        sys_clk,
  input wire        arst_n,
  input wire        fetch_advance,
  input wire        jump_valid,
  input wire [8:0]  jump_target,
  input wire [10:0] prog_addr,
  input wire        op_valid,
  input wire        op_ready,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest
);
  // Counter width of the variant
  localparam [10:0] MASK = (VARIANT < 3'h2) ? 11'h1ff :
                           (VARIANT == 3'h2) ? 11'h3ff : 11'h7ff;
  // File writes may load the counter, so those cycles are skipped
  wire quiet = !op_valid && !avs_write;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_pc_width: assert property ((prog_addr & ~MASK) == 11'h000)
    else $error("counter beyond variant width");
  a_reset_vector: assert property ($rose(arst_n) |-> prog_addr == MASK)
    else $error("fetch does not start at last word");
  a_vector_wrap: assert property (fetch_advance && !jump_valid && quiet &&
    prog_addr == MASK |=> prog_addr == 11'h000)
    else $error("increment past top did not reach zero");
  a_pc_advance: assert property (fetch_advance && !jump_valid && quiet
    |=> prog_addr == (($past(prog_addr) + 11'h001) & MASK))
    else $error("counter advance wrong");
  a_jump_low: assert property (jump_valid && quiet
    |=> prog_addr[8:0] == $past(jump_target))
    else $error("jump low bits wrong");
  a_op_answer: assert property (op_valid |=> op_ready)
    else $error("operand access not answered");
  a_ready_cause: assert property (op_ready |-> $past(op_valid))
    else $error("ready without access");
  a_bus_answer: assert property ((avs_read || avs_write) &&
    avs_waitrequest && !op_valid |=> !avs_waitrequest)
    else $error("bus request not served");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge longer than one cycle");
  a_ack_cause: assert property ($fell(avs_waitrequest)
    |-> $past(avs_read || avs_write))
    else $error("acknowledge without request");
endmodule // mmd_map_monitor

bind mmd_memory_map mmd_map_monitor #(.VARIANT(VARIANT)) u_mon (
  .sys_clk(sys_clk), .arst_n(arst_n), .fetch_advance(fetch_advance),
  .jump_valid(jump_valid), .jump_target(jump_target),
  .prog_addr(prog_addr), .op_valid(op_valid), .op_ready(op_ready),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest));

// ===== sim/mmd_core_model.sv
/*
  Core model: drives fetch requests and operand accesses.
  Assumes the decoder answers operands exactly one cycle later.
*/
`timescale 1ns/100ps
// ========================================
// Core model
module mmd_core_model (
  input  wire       sys_clk,
  input  wire [7:0] op_rdata,
  input  wire       op_ready,
  output reg        fetch_advance,
  output reg        jump_valid,
  output reg  [8:0] jump_target,
  output reg        op_valid,
  output reg        op_write,
  output reg  [4:0] op_addr,
  output reg  [7:0] op_wdata,
  output reg        flags_we,
  output reg  [2:0] flags_in,
  output reg        option_we,
  output reg  [5:0] option_wdata
);
  // Idle from time zero so nothing is requested during reset
  initial begin
    {fetch_advance, jump_valid, jump_target, op_valid} = 12'h000;
    {op_write, op_addr, op_wdata} = 14'h0000;
    {flags_we, flags_in, option_we, option_wdata} = 11'h000;
  end
  // One operand access; answer taken where op_ready stands
  task op_rw(input wr, input [4:0] a, input [7:0] d, output [8:0] q);
    begin
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_write <= wr;
      op_addr <= a;
      op_wdata <= d;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      @(negedge sys_clk);
      q = {op_ready, op_rdata};
    end
  endtask
  // One cycle of fetch request
  task step(input adv, input jv, input [8:0] t);
    begin
      @(posedge sys_clk);
      fetch_advance <= adv;
      jump_valid <= jv;
      jump_target <= t;
      @(posedge sys_clk);
      fetch_advance <= 1'b0;
      jump_valid <= 1'b0;
      @(negedge sys_clk);
    end
  endtask
  // Flag hardware and prescaler write in the same cycle
  task cfg(input [2:0] fi, input [5:0] od);
    begin
      @(posedge sys_clk);
      {flags_we, flags_in, option_we, option_wdata} <= {1'b1, fi, 1'b1, od};
      @(posedge sys_clk);
      {flags_we, option_we} <= 2'b00;
    end
  endtask
endmodule // mmd_core_model

// ===== sim/tb_mmd_memory_map.sv
/*
  Self-checking bench for the memory map decoder, largest variant,
  with a small third-port variant fed the same stimulus alongside.
  Assumes a 50 MHz clock and an Avalon-MM master held by this bench.
*/
`timescale 1ns/100ps
// ========================================
// Bench
module tb_mmd_memory_map;
  reg         sys_clk, arst_n, avs_read, avs_write;
  reg  [9:0]  avs_address;
  reg  [31:0] avs_writedata;
  reg  [3:0]  avs_byteenable, pin_a_in;
  reg  [7:0]  pin_b_in;
  reg         dir_we;
  reg  [1:0]  dir_sel;
  reg  [7:0]  dir_wdata;
  wire [3:0]  pin_a_out, pin_a_oe;
  wire [7:0]  pin_b_out, pin_b_oe, pin_c_out, pin_c_oe, small_pin_c_out;
  wire [10:0] small_prog_addr;
  wire        fetch_advance, jump_valid, op_valid, op_write, op_ready;
  wire        flags_we, option_we, avs_waitrequest;
  wire [8:0]  jump_target;
  wire [10:0] prog_addr;
  wire [4:0]  op_addr;
  wire [7:0]  op_wdata, op_rdata;
  wire [2:0]  flags_in;
  wire [5:0]  option_wdata, option_value;
  wire [31:0] avs_readdata;
  integer     fails, comparisons, cycles;
  reg  [31:0] q;
  reg  [8:0]  cq;
  mmd_core_model core (.sys_clk(sys_clk), .op_rdata(op_rdata),
    .op_ready(op_ready), .fetch_advance(fetch_advance),
    .jump_valid(jump_valid), .jump_target(jump_target),
    .op_valid(op_valid), .op_write(op_write), .op_addr(op_addr),
    .op_wdata(op_wdata), .flags_we(flags_we), .flags_in(flags_in),
    .option_we(option_we), .option_wdata(option_wdata));
  mmd_memory_map #(.VARIANT(3'h4)) dut (.sys_clk(sys_clk),
    .arst_n(arst_n), .fetch_advance(fetch_advance),
    .jump_valid(jump_valid), .jump_target(jump_target),
    .prog_addr(prog_addr), .op_valid(op_valid), .op_write(op_write),
    .op_addr(op_addr), .op_wdata(op_wdata), .op_rdata(op_rdata),
    .op_ready(op_ready), .flags_we(flags_we), .flags_in(flags_in),
    .dir_we(dir_we), .dir_sel(dir_sel), .dir_wdata(dir_wdata),
    .option_we(option_we), .option_wdata(option_wdata),
    .option_value(option_value), .pin_a_in(pin_a_in),
    .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_in(pin_b_in),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .pin_c_in(8'h00),
    .pin_c_out(pin_c_out), .pin_c_oe(pin_c_oe),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // Small variant with the third port; same inputs, so same timing
  mmd_memory_map #(.VARIANT(3'h1)) dut_small (.sys_clk(sys_clk),
    .arst_n(arst_n), .fetch_advance(fetch_advance),
    .jump_valid(jump_valid), .jump_target(jump_target),
    .prog_addr(small_prog_addr), .op_valid(op_valid),
    .op_write(op_write), .op_addr(op_addr), .op_wdata(op_wdata),
    .op_rdata(), .op_ready(), .flags_we(flags_we),
    .flags_in(flags_in), .dir_we(dir_we), .dir_sel(dir_sel),
    .dir_wdata(dir_wdata), .option_we(option_we),
    .option_wdata(option_wdata), .option_value(),
    .pin_a_in(pin_a_in), .pin_a_out(), .pin_a_oe(),
    .pin_b_in(pin_b_in), .pin_b_out(), .pin_b_oe(),
    .pin_c_in(8'h00), .pin_c_out(small_pin_c_out), .pin_c_oe(),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(),
    .avs_waitrequest());
  // Compare and report
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Bus cycle held until waitrequest is sampled low at a rising edge;
  // data is taken at that edge and the request dropped right after it
  task bus(input wr, input [7:0] idx, input [7:0] d);
    begin
      @(posedge sys_clk);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h000000, d};
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task br(input [7:0] idx, input [31:0] exp);
    begin bus(1'b0, idx, 8'h00); chk(q, exp); end
  endtask
  task cw(input [4:0] a, input [7:0] d);
    begin core.op_rw(1'b1, a, d, cq); end
  endtask
  task cr(input [4:0] a, input [7:0] exp);
    begin core.op_rw(1'b0, a, 8'h00, cq); chk(cq, {1'b1, exp}); end
  endtask
  // ========================================
  // Scenarios
  task t_reset;
    begin
      chk(prog_addr, 11'h7ff);
      chk(small_prog_addr, 11'h1ff);
      br(8'h03, 32'h18);
      br(8'h04, 32'h80);
      br(8'h20, 32'hff);
      br(8'h23, 32'h3f);
      br(8'h24, 32'h7ff);
      $display("t_reset done");
    end
  endtask
  task t_wrap;
    begin
      core.step(1'b1, 1'b0, 9'h000);
      chk(prog_addr, 11'h000);
      chk(small_prog_addr, 11'h000);
      core.step(1'b1, 1'b0, 9'h000);
      chk(prog_addr, 11'h001);
      $display("t_wrap done");
    end
  endtask
  // Page bits steer jumps and low-byte writes into the top page
  task t_page;
    begin
      bus(1'b1, 8'h03, 8'h60);
      br(8'h03, 32'h78);
      core.step(1'b0, 1'b1, 9'h005);
      chk(prog_addr, 11'h605);
      chk(small_prog_addr, 11'h005);
      cw(5'h02, 8'h34);
      chk(prog_addr, 11'h634);
      bus(1'b1, 8'h24, 8'h00);
      br(8'h24, 32'h634);
      cr(5'h02, 8'h34);
      $display("t_page done");
    end
  endtask
  task t_indirect;
    begin
      cw(5'h08, 8'h5a);
      cw(5'h04, 8'h08);
      cr(5'h00, 8'h5a);
      cw(5'h00, 8'hc3);
      cr(5'h08, 8'hc3);
      cr(5'h04, 8'h88);
      $display("t_indirect done");
    end
  endtask
  // Same file address, two banks, back to back
  task t_bank;
    begin
      cw(5'h04, 8'h00);
      cw(5'h10, 8'h11);
      cw(5'h04, 8'h20);
      cw(5'h10, 8'h22);
      cr(5'h10, 8'h22);
      cw(5'h04, 8'h00);
      cr(5'h10, 8'h11);
      cw(5'h07, 8'ha5);
      cr(5'h07, 8'ha5);
      cw(5'h1f, 8'h3c);
      cr(5'h1f, 8'h3c);
      $display("t_bank done");
    end
  endtask
  task t_side;
    begin
      br(8'h06, 32'h96);
      br(8'h05, 32'h06);
      core.cfg(3'h5, 6'h2a);
      br(8'h23, 32'h2a);
      chk(option_value, 6'h2a);
      br(8'h03, 32'h7d);
      bus(1'b1, 8'h30, 8'hff);
      br(8'h30, 32'h00);
      avs_byteenable <= 4'h0;
      bus(1'b1, 8'h08, 8'h00);
      avs_byteenable <= 4'hf;
      br(8'h08, 32'hc3);
      $display("t_side done");
    end
  endtask
  // Latches and directions reach the pins one registered stage later;
  // the direction of B comes from the core strobe, that of A by bus
  task t_pins;
    begin
      cw(5'h05, 8'hfa);
      cw(5'h06, 8'h5c);
      bus(1'b1, 8'h20, 8'hf0);
      @(posedge sys_clk);
      dir_we <= 1'b1;
      dir_sel <= 2'h1;
      dir_wdata <= 8'h0f;
      @(posedge sys_clk);
      dir_we <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk(pin_a_out, 4'ha);
      chk(pin_a_oe, 4'hf);
      chk(pin_b_out, 8'h5c);
      chk(pin_b_oe, 8'hf0);
      chk({pin_c_out, pin_c_oe}, 16'h0000);
      chk(small_pin_c_out, 8'ha5);
      br(8'h21, 32'h0f);
      cr(5'h05, 8'h06);
      $display("t_pins done");
    end
  endtask
  // ========================================
  // Clock, timeout and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  initial begin
    {arst_n, avs_read, avs_write, avs_address} = 13'h0000;
    {avs_writedata, avs_byteenable} = 36'hf;
    pin_a_in = 4'h6; // Held early so the synchronisers settle
    pin_b_in = 8'h96;
    {fails, comparisons, cycles} = 0;
    {dir_we, dir_sel, dir_wdata} = 11'h000;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    t_reset;
    t_wrap;
    t_page;
    t_indirect;
    t_bank;
    t_side;
    t_pins;
    end_of_test;
  end
endmodule // tb_mmd_memory_map
